/* File: logic/lfs_supervisor.sv */
// Purpose: Fault supervisor for a three-string LED driver with boost stage.
// Assumes: All comparator flags are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module lfs_supervisor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic supply_lockout,
  input wire logic die_overtemp_shutdown,
  input wire logic thermistor_input,
  input wire logic dim_on,
  input wire logic sense_above_3v1,
  input wire logic sense_above_6v0,
  input wire logic output_overvoltage_trip,
  input wire logic output_undervoltage_trip,
  input wire logic cathode_feedback_low,
  input wire logic current_limit_max,
  input wire logic delay_capacitor_grounded,
  input wire logic string_off_grounded,
  input wire logic string_off_for_channels,
  input wire logic softstart_done,
  output logic shutdown,
  output logic standby,
  output logic softstart_req,
  output logic strings_enable,
  output logic string_off_signal,
  output logic fault_type1,
  output logic fault_type2,
  output logic fault_type3,
  output logic auto_restart,
  output logic [11:0] delay_level
);
  import lfs_pkg::*;
  lfs_state_t state;
  lfs_state_t next_state;
  lfs_ramp_if rif ();
  logic blank_ok;
  logic sense_ok;
  logic cathode_latched;
  logic f1;
  logic f2_on_time;
  logic f2_always;
  logic f2;
  logic f3;
  logic ov_shut;
  logic sampled;
  lfs_ramp_t next_dir;
  logic running;

  lfs_ramp u_ramp (
    .clk(clk),
    .sys_rst(sys_rst),
    .rif(rif)
  );

  lfs_blank u_blank (
    .clk(clk),
    .sys_rst(sys_rst),
    .strings_on(strings_enable),
    .ok(blank_ok)
  );

  assign running = (state == LFS_RUN);
  assign sense_ok = running && dim_on && blank_ok;
  assign f1 = sense_ok && sense_above_3v1 && !sense_above_6v0;
  assign f2_on_time = sense_ok && (sense_above_6v0 || current_limit_max);
  assign f2_always = running && (output_overvoltage_trip ||
                                 output_undervoltage_trip);
  assign f2 = f2_on_time || f2_always || cathode_latched;
  assign f3 = !enable || supply_lockout || die_overtemp_shutdown ||
              thermistor_input;

  // The cathode check is made on the last soft-start cycle, while done still stands.
  always_ff @(posedge clk) begin
    if (sys_rst || !(state == LFS_SOFTSTART || state == LFS_RUN)) begin
      cathode_latched <= 1'b0;
    end else if (state == LFS_SOFTSTART && softstart_done && cathode_feedback_low) begin
      cathode_latched <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      auto_restart <= 1'b0;
      sampled <= 1'b0;
    end else if (state == LFS_STANDBY) begin
      sampled <= 1'b0;
    end else if (state == LFS_SOFTSTART && !sampled) begin
      sampled <= 1'b1;
      auto_restart <= string_off_grounded && !string_off_for_channels;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ov_shut <= 1'b0;
    end else if (state == LFS_RUN && next_state == LFS_SHUT_HOLD) begin
      ov_shut <= output_overvoltage_trip;
    end else if (!output_overvoltage_trip) begin
      ov_shut <= 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    if (f3) begin
      next_state = LFS_STANDBY;
    end else begin
      case (state)
        LFS_STANDBY: next_state = LFS_SOFTSTART;
        LFS_SOFTSTART: begin
          if (softstart_done) begin
            next_state = LFS_RUN;
          end
        end
        LFS_RUN: begin
          if (f2 && !delay_capacitor_grounded && rif.level >= RAMP_TRIP) begin
            next_state = LFS_SHUT_HOLD;
          end
        end
        LFS_SHUT_HOLD: begin
          if (auto_restart && !ov_shut) begin
            next_state = LFS_SHUT_DISCH;
          end
        end
        LFS_SHUT_DISCH: begin
          if (rif.level <= RAMP_RESTART) begin
            next_state = LFS_SOFTSTART;
          end
        end
        default: next_state = LFS_STANDBY;
      endcase
    end
  end

  always_comb begin
    next_dir = LFS_RAMP_IDLE;
    case (state)
      LFS_RUN: begin
        if (f1 || f2) begin
          next_dir = LFS_RAMP_UP;
        end else if (dim_on || !(sense_above_3v1 || sense_above_6v0)) begin
          next_dir = LFS_RAMP_DOWN;
        end
      end
      LFS_SHUT_HOLD: next_dir = auto_restart ? LFS_RAMP_IDLE : LFS_RAMP_UP;
      LFS_SHUT_DISCH: next_dir = LFS_RAMP_DOWN;
      default: next_dir = LFS_RAMP_IDLE;
    endcase
    if (delay_capacitor_grounded) begin
      next_dir = LFS_RAMP_IDLE;
    end
  end

  assign rif.dir = next_dir;
  assign rif.clear = (state == LFS_STANDBY) || delay_capacitor_grounded;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= LFS_STANDBY;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shutdown <= 1'b0;
      standby <= 1'b1;
      softstart_req <= 1'b0;
      strings_enable <= 1'b0;
      string_off_signal <= 1'b1;
      fault_type1 <= 1'b0;
      fault_type2 <= 1'b0;
      fault_type3 <= 1'b0;
      delay_level <= 12'h000;
    end else begin
      shutdown <= (next_state == LFS_SHUT_HOLD) || (next_state == LFS_SHUT_DISCH);
      standby <= (next_state == LFS_STANDBY);
      softstart_req <= (next_state == LFS_SOFTSTART);
      strings_enable <= (next_state == LFS_RUN) && dim_on;
      string_off_signal <= !((next_state == LFS_RUN) && dim_on);
      fault_type1 <= f1;
      fault_type2 <= f2;
      fault_type3 <= f3;
      delay_level <= rif.level;
    end
  end
endmodule
`default_nettype wire

/* File: logic/lfs_pkg.sv */
// Purpose: Constants and types shared by the LED fault supervisor.
// Assumes: Delay ramp modelled as a counter in units of one code per step.
// Notes: Ramp codes map voltages at 1 mV per code.
package lfs_pkg;
  localparam int CLK_MHZ = 125;
  localparam int BLANK_NS = 1600;
  localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int RAMP_W = 12;
  localparam logic [11:0] RAMP_CEIL = 12'he10;
  localparam logic [11:0] RAMP_TRIP = 12'haf0;
  localparam logic [11:0] RAMP_RESTART = 12'h15e;
  localparam logic [11:0] RAMP_RESET = 12'h000;
  localparam int CHG_DIV = 4;
  localparam int DIS_DIV = 127;
  localparam logic [7:0] CHG_DIV_M1 = 8'h03;
  localparam logic [7:0] DIS_DIV_M1 = 8'h7e;
  localparam logic [7:0] BLANK_M1 = 8'hc7;
  typedef enum logic [2:0] {
    LFS_STANDBY, LFS_SOFTSTART, LFS_RUN, LFS_SHUT_HOLD, LFS_SHUT_DISCH
  } lfs_state_t;
  typedef enum logic [1:0] {LFS_RAMP_IDLE, LFS_RAMP_UP, LFS_RAMP_DOWN} lfs_ramp_t;
endpackage

/* File: logic/lfs_ramp_if.sv */
// Purpose: Carries ramp direction and level between controller and counter.
// Assumes: Single clock domain.
// Notes: Controller drives direction and clear; counter returns level.
`timescale 1ns/1ps
`default_nettype none
interface lfs_ramp_if;
  import lfs_pkg::*;
  lfs_ramp_t dir;
  logic clear;
  logic [11:0] level;
  modport ctrl (output dir, output clear, input level);
  modport ramp (input dir, input clear, output level);
endinterface
`default_nettype wire

/* File: logic/lfs_ramp.sv */
// Purpose: Delay capacitor ramp as an up/down counter with rate dividers.
// Assumes: Charge and discharge rates set by package dividers.
// Notes: Level saturates at the ceiling and at zero.
`timescale 1ns/1ps
`default_nettype none
module lfs_ramp (
  input wire logic clk,
  input wire logic sys_rst,
  lfs_ramp_if.ramp rif
);
  import lfs_pkg::*;
  logic [7:0] pre;
  logic [11:0] level;
  assign rif.level = level;
  always_ff @(posedge clk) begin
    if (sys_rst || rif.clear || rif.dir == LFS_RAMP_IDLE) begin
      pre <= 8'h00;
    end else if ((rif.dir == LFS_RAMP_UP && pre == CHG_DIV_M1) ||
                 (rif.dir == LFS_RAMP_DOWN && pre == DIS_DIV_M1)) begin
      pre <= 8'h00;
    end else begin
      pre <= pre + 8'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst || rif.clear) begin
      level <= RAMP_RESET;
    end else if (rif.dir == LFS_RAMP_UP && pre == CHG_DIV_M1 && level < RAMP_CEIL) begin
      level <= level + 12'h001;
    end else if (rif.dir == LFS_RAMP_DOWN && pre == DIS_DIV_M1 && level != 12'h000) begin
      level <= level - 12'h001;
    end
  end
endmodule
`default_nettype wire

/* File: logic/lfs_blank.sv */
// Purpose: Blanking timer after each string turn-on.
// Assumes: strings_on is a synchronous level.
// Notes: ok rises once the blanking count has elapsed.
`timescale 1ns/1ps
`default_nettype none
module lfs_blank (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic strings_on,
  output logic ok
);
  import lfs_pkg::*;
  logic [7:0] cnt;
  always_ff @(posedge clk) begin
    if (sys_rst || !strings_on) begin
      cnt <= 8'h00;
      ok <= 1'b0;
    end else if (cnt == BLANK_M1) begin
      ok <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: sim/lfs_analog.sv */
// Purpose: Boost stage stand-in that answers soft-start requests.
// Assumes: Soft start lasts 50 cycles.
// Notes: Done drops as soon as the request is withdrawn.
`timescale 1ns/1ps
`default_nettype none
module lfs_analog (
  input wire logic clk,
  input wire logic softstart_req,
  output logic softstart_done
);
  int cnt = 0;
  always_ff @(posedge clk) begin
    cnt <= softstart_req ? cnt + 1 : 0;
  end
  assign softstart_done = softstart_req && cnt >= 50;
endmodule
`default_nettype wire

/* File: sim/lfs_supervisor_properties.sv */
// Purpose: Checker for the fault supervisor.
// Assumes: One clock, synchronous reset.
// Notes: Bound to the top module.
`timescale 1ns/1ps
`default_nettype none
module lfs_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic string_off_grounded,
  input wire logic string_off_for_channels,
  input wire logic output_overvoltage_trip,
  input wire logic delay_capacitor_grounded,
  input wire logic shutdown,
  input wire logic standby,
  input wire logic softstart_req,
  input wire logic string_off_signal,
  input wire logic auto_restart,
  input wire logic [11:0] delay_level
);
  import lfs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_trip; $rose(shutdown); endsequence
  sequence s_restart; $fell(shutdown) && !standby; endsequence
  a_type3_standby: assert property (!enable |=> standby)
    else $error("no standby");
  a_standby_nocharge: assert property (standby |=> delay_level <= $past(delay_level))
    else $error("ramp rose");
  a_ramp_ceiling: assert property (delay_level <= RAMP_CEIL)
    else $error("above ceiling");
  a_trip_level: assert property (s_trip |-> delay_level >= RAMP_TRIP)
    else $error("early shutdown");
  a_grounded_noshut: assert property (delay_capacitor_grounded &&
    $past(delay_capacitor_grounded) |-> !$rose(shutdown)) else $error("grounded shutdown");
  a_off_standby: assert property (standby |-> string_off_signal)
    else $error("string off low");
  a_auto_source: assert property ($rose(auto_restart) |->
    $past(string_off_grounded) && !$past(string_off_for_channels)) else $error("bad auto");
  a_restart_low: assert property (s_restart |->
    softstart_req && delay_level <= RAMP_RESTART) else $error("early restart");
  a_ov_hold: assert property (shutdown && output_overvoltage_trip |=>
    standby || delay_level >= $past(delay_level)) else $error("ramp fell");
endmodule
bind lfs_supervisor lfs_props i_props (.*);
`default_nettype wire

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the fault supervisor.
// Assumes: Inputs change at the falling edge.
// Notes: Waits follow the package ramp rates.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lfs_pkg::*;
  logic clk = 0;
  logic sys_rst = 1;
  logic [3:0] t3 = 4'h0;
  logic dim_on = 0, sense_above_3v1 = 0, sense_above_6v0 = 0, output_overvoltage_trip = 0;
  logic output_undervoltage_trip = 0, cathode_feedback_low = 0, current_limit_max = 0;
  logic delay_capacitor_grounded = 0, string_off_grounded = 0, string_off_for_channels = 0;
  logic softstart_done, shutdown, standby, softstart_req, strings_enable, string_off_signal;
  logic fault_type1, fault_type2, fault_type3, auto_restart;
  logic [11:0] delay_level;
  wire enable = ~t3[3];
  wire supply_lockout = t3[0];
  wire die_overtemp_shutdown = t3[1];
  wire thermistor_input = t3[2];
  int n_mismatch = 0, checks = 0;
  always #4 clk = ~clk;
  lfs_supervisor i_dut (.*);
  lfs_analog i_ana (.*);
  task w(int n);
    repeat (n) @(negedge clk);
  endtask
  task chk(string name, logic [11:0] seen, logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task cyc_en();
    t3 = 4'h8;
    w(5);
    t3 = 4'h0;
    w(300);
  endtask
  task t_type1();
    logic [11:0] lv;
    dim_on = 1;
    sense_above_3v1 = 1;
    w(2000);
    chk("type1", fault_type1, 1);
    dim_on = 0;
    w(2);
    lv = delay_level;
    chk("charge", lv > 12'h100, 1);
    w(400);
    chk("frozen", delay_level, lv);
    dim_on = 1;
    w(15000);
    chk("run", shutdown, 0);
    chk("ceil", delay_level, RAMP_CEIL);
    sense_above_3v1 = 0;
    w(1300);
    chk("drain", delay_level < RAMP_CEIL, 1);
    $display("t_type1 done");
  endtask
  task t_type3();
    for (int i = 0; i < 4; i++) begin
      t3 = 4'h1 << i;
      w(3);
      chk("stby", standby, 1);
      chk("type3", fault_type3, 1);
      chk("clear", delay_level, RAMP_RESET);
      t3 = 4'h0;
      w(300);
      chk("back", standby, 0);
    end
    $display("t_type3 done");
  endtask
  task t_ov();
    output_overvoltage_trip = 1;
    dim_on = 0;
    w(11600);
    chk("trip", shutdown, 1);
    w(3600);
    chk("hold", delay_level, RAMP_CEIL);
    output_overvoltage_trip = 0;
    w(500);
    chk("latch", shutdown, 1);
    cyc_en();
    chk("resume", shutdown, 0);
    $display("t_ov done");
  endtask
  task t_ground();
    delay_capacitor_grounded = 1;
    output_overvoltage_trip = 1;
    w(12000);
    chk("noshut", shutdown, 0);
    output_overvoltage_trip = 0;
    delay_capacitor_grounded = 0;
    $display("t_ground done");
  endtask
  task t_auto();
    string_off_grounded = 1;
    string_off_for_channels = 1;
    cyc_en();
    chk("auto0", auto_restart, 0);
    string_off_for_channels = 0;
    cyc_en();
    chk("auto1", auto_restart, 1);
    output_overvoltage_trip = 1;
    w(12000);
    chk("trip", shutdown, 1);
    w(1000);
    chk("below", delay_level < RAMP_CEIL, 1);
    chk("held", delay_level >= RAMP_TRIP, 1);
    output_overvoltage_trip = 0;
    w(600);
    chk("disch", delay_level < RAMP_TRIP, 1);
    $display("t_auto done");
  endtask
  task t_type2();
    dim_on = 0;
    w(10);
    chk("off_hi", string_off_signal, 1);
    dim_on = 1;
    sense_above_6v0 = 1;
    w(100);
    chk("blank", fault_type2, 0);
    w(200);
    chk("short6", fault_type2, 1);
    chk("off_lo", string_off_signal, 0);
    sense_above_6v0 = 0;
    output_undervoltage_trip = 1;
    dim_on = 0;
    w(10);
    chk("uvp", fault_type2, 1);
    output_undervoltage_trip = 0;
    cathode_feedback_low = 1;
    cyc_en();
    chk("cath", fault_type2, 1);
    cathode_feedback_low = 0;
    w(10);
    chk("cath_kept", fault_type2, 1);
    cyc_en();
    $display("t_type2 done");
  endtask
  task final_report();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #800000;
    n_mismatch++;
    final_report();
  end
  initial begin
    w(12);
    sys_rst = 0;
    w(300);
    t_type1();
    t_type3();
    t_ov();
    t_ground();
    t_type2();
    t_auto();
    final_report();
  end
endmodule
`default_nettype wire
